/* design/ebp_pkg.sv */
/*
 Shared types and constants for the external bus pin controller.
 Assumes a single core clock and a synchronous active-high reset.
*/
// What this block does
// - Internal accesses keep all chip selects high
// - Internal accesses keep read and write strobes high
// - Internal accesses float data lanes, drive address
// - Hold strobe marks address on shared lines
// - Byte select low for upper/word, high lower
// - Upper write strobe or lower byte select
// - Lower write strobe low on writes only
// - Byte lanes carry address and data per size
// - No upper strobe function in 8-bit space
// - Standby keeps keep-state and bus pin levels, drops ctl_oe and cs_oe, floats inputs
// - Float bit floats keep-state outputs in standby
// - Wait pull-up follows its control bit
// - External memory drives only accessed area select
package ebp_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int AREA_N = 8;
  localparam int PC_W = 8;

  localparam logic [7:0] CS_IDLE = 8'hff;
  localparam logic [7:0] IO_SEL = 8'hbf;
  localparam logic [1:0] LANES_NONE = 2'h0;
  localparam logic [1:0] LANES_LOW = 2'h1;
  localparam logic [1:0] LANES_HIGH = 2'h2;
  localparam logic [1:0] LANES_BOTH = 2'h3;

  typedef enum logic [1:0] {
    SP_INT = 2'h0,
    SP_MUXIO = 2'h1,
    SP_EXT = 2'h2
  } ebp_space_t;

  typedef enum logic [1:0] {
    SZ_UPPER = 2'h0,
    SZ_LOWER = 2'h1,
    SZ_WORD = 2'h2
  } ebp_size_t;

  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_SLEEP = 3'h1,
    PM_STBY = 3'h2,
    PM_POR = 3'h3,
    PM_MRST = 3'h4,
    PM_REL = 3'h5
  } ebp_pwr_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_DONE = 4'h8
  } ebp_st_t;

  typedef struct packed {
    ebp_space_t space;
    logic [2:0] area;
    logic bus16;
    ebp_size_t size;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebp_req_t;

  typedef struct packed {
    logic [AREA_N-1:0] area_selects_n;
    logic address_hold_strobe;
    logic read_strobe_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
    logic address_bit_zero;
    logic [ADDR_W-1:1] address_outputs;
    logic row_strobe_n;
    logic upper_column_strobe_n;
    logic lower_column_strobe_n;
    logic [DATA_W-1:0] ad_out;
    logic [1:0] ad_oe;
  } ebp_pins_t;

  localparam ebp_pins_t PINS_IDLE = '{
    area_selects_n: CS_IDLE,
    address_hold_strobe: 1'b0,
    read_strobe_n: 1'b1,
    upper_write_strobe_n: 1'b1,
    lower_write_strobe_n: 1'b1,
    address_bit_zero: 1'b0,
    address_outputs: 21'h0,
    row_strobe_n: 1'b1,
    upper_column_strobe_n: 1'b1,
    lower_column_strobe_n: 1'b1,
    ad_out: 16'h0,
    ad_oe: LANES_NONE
  };

  localparam ebp_req_t REQ_RST = '0;

endpackage : ebp_pkg

/* design/ebp_sync3.sv */
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous pin inputs and the core clock.
*/
`timescale 1ns/10ps
module ebp_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] q_next;

  // Take a change once stages two and three agree
  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        q_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule : ebp_sync3

/* design/ebp_pin_ctrl.sv */
/*
 External bus and control pin controller: access sequencing,
 strobe and lane driving, and power-state pin behaviour.
 Assumes the requester holds a request until req_ready and that
 the shared data lines are sampled synchronously to core_clk.
*/
`timescale 1ns/10ps
module ebp_pin_ctrl #(
  parameter int KEEP_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Access request
  input wire logic req_valid,
  input wire ebp_pkg::ebp_req_t req,
  output logic req_ready,
  output logic acc_done,
  output logic [15:0] rd_data,
  // Configuration
  input wire ebp_pkg::ebp_pwr_t pwr_mode,
  input wire logic sep_strobe,
  input wire logic standby_float_bit,
  input wire logic wait_pullup_bit,
  // Bus pins
  output ebp_pkg::ebp_pins_t bus_pins,
  output logic ctl_oe,
  output logic cs_oe,
  input wire logic [15:0] muxed_addr_data_lines_in,
  output logic upper_parity_pin_out,
  output logic upper_parity_pin_oe,
  output logic lower_parity_pin_out,
  output logic lower_parity_pin_oe,
  // Wait pin
  input wire logic wait_n_pin,
  output logic wait_pullup_en,
  // Port C
  input wire logic [7:0] port_c_inputs,
  output logic port_c_ie,
  output logic [7:0] port_c_data,
  // Keep-state pins
  input wire logic [KEEP_W-1:0] keep_val,
  input wire logic [KEEP_W-1:0] keep_dir,
  output logic [KEEP_W-1:0] keep_out,
  output logic [KEEP_W-1:0] keep_oe
);

  import ebp_pkg::*;

  ebp_st_t st_reg, st_next;
  ebp_req_t req_reg, req_next;
  ebp_pins_t pins_reg, pins_next;
  logic [15:0] rd_reg, rd_next;
  logic ctl_oe_reg, ctl_oe_next, cs_oe_reg, cs_oe_next;
  logic pu_reg, pu_next, pcie_reg, pcie_next;
  logic [7:0] pc_reg, pc_next;
  logic [KEEP_W-1:0] ko_reg, ko_next, koe_reg, koe_next;
  logic [8:0] sync_q;
  logic wait_ok, stby, run;

  ebp_sync3 #(.W(9)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .d({wait_n_pin, port_c_inputs}),
    .q(sync_q)
  );

  assign wait_ok = sync_q[8];
  assign stby = (pwr_mode == PM_STBY);
  assign run = (pwr_mode == PM_RUN);

  // Pin levels for a given state and access
  function automatic ebp_pins_t drive(ebp_st_t st, ebp_req_t r, logic sep);
    ebp_pins_t p;
    logic up, lo, wd, w;
    logic [1:0] lanes;
    p = PINS_IDLE;
    up = (r.size == SZ_UPPER);
    lo = (r.size == SZ_LOWER);
    wd = (r.size == SZ_WORD);
    w = r.write;
    lanes = !r.bus16 ? LANES_LOW : up ? LANES_HIGH : lo ? LANES_LOW : LANES_BOTH;
    p.address_outputs = r.addr[ADDR_W-1:1];
    p.address_bit_zero = r.addr[0];
    if ((st == ST_ADDR || st == ST_DATA) && r.space != SP_INT) begin
      if (r.space == SP_MUXIO) begin
        p.area_selects_n = IO_SEL;
      end else begin
        p.area_selects_n = CS_IDLE & ~(8'h01 << r.area);
      end
      if (r.bus16 && (r.space == SP_MUXIO || !sep)) begin
        p.address_bit_zero = lo;
      end
      if (st == ST_ADDR) begin
        p.address_hold_strobe = 1'b1;
        p.ad_out = r.addr[15:0];
        p.ad_oe = r.bus16 ? LANES_BOTH : LANES_LOW;
      end else begin
        p.read_strobe_n = w;
        if (r.bus16) begin
          if (sep) begin
            p.upper_write_strobe_n = !(w && (up || wd));
            p.lower_write_strobe_n = !(w && (lo || wd));
          end else begin
            p.upper_write_strobe_n = !(lo || wd);
            p.lower_write_strobe_n = !w;
          end
        end else begin
          p.upper_write_strobe_n = 1'b1;
          p.lower_write_strobe_n = !w;
        end
        p.ad_out = r.wdata;
        p.ad_oe = w ? lanes : LANES_NONE;
      end
    end
    return p;
  endfunction : drive

  // Access sequencer
  always_comb begin
    st_next = st_reg;
    req_next = req_reg;
    rd_next = rd_reg;
    case (st_reg)
      ST_IDLE: begin
        if (req_valid && run) begin
          req_next = req;
          st_next = (req.space == SP_MUXIO) ? ST_ADDR : ST_DATA;
        end
      end
      ST_ADDR: begin
        st_next = ST_DATA;
      end
      ST_DATA: begin
        if (req_reg.space == SP_INT || wait_ok) begin
          st_next = ST_DONE;
          if (!req_reg.write && req_reg.space != SP_INT) begin
            rd_next = muxed_addr_data_lines_in;
          end
        end
      end
      ST_DONE: begin
        st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    if (pwr_mode == PM_POR || pwr_mode == PM_MRST) begin
      st_next = ST_IDLE;
    end
    if (stby) begin
      st_next = st_reg;
      req_next = req_reg;
    end
  end

  // Pin levels, enables and power-state pins
  always_comb begin
    pins_next = drive(st_next, req_next, sep_strobe);
    ctl_oe_next = !(stby || pwr_mode == PM_REL);
    cs_oe_next = ctl_oe_next && (pwr_mode != PM_POR);
    pu_next = wait_pullup_bit;
    pcie_next = !(pwr_mode == PM_POR || stby);
    pc_next = pcie_next ? sync_q[7:0] : pc_reg;
    ko_next = keep_val;
    koe_next = keep_dir;
    if (stby) begin
      pins_next = pins_reg;
      ko_next = ko_reg;
      koe_next = standby_float_bit ? '0 : koe_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
      req_reg <= REQ_RST;
      rd_reg <= 16'h0;
      pins_reg <= PINS_IDLE;
      ctl_oe_reg <= 1'b0;
      cs_oe_reg <= 1'b0;
      pu_reg <= 1'b0;
      pcie_reg <= 1'b0;
      pc_reg <= 8'h0;
      ko_reg <= '0;
      koe_reg <= '0;
    end else begin
      st_reg <= st_next;
      req_reg <= req_next;
      rd_reg <= rd_next;
      pins_reg <= pins_next;
      ctl_oe_reg <= ctl_oe_next;
      cs_oe_reg <= cs_oe_next;
      pu_reg <= pu_next;
      pcie_reg <= pcie_next;
      pc_reg <= pc_next;
      ko_reg <= ko_next;
      koe_reg <= koe_next;
    end
  end

  assign req_ready = (st_reg == ST_IDLE) && run;
  assign acc_done = (st_reg == ST_DONE);
  assign rd_data = rd_reg;
  assign bus_pins = pins_reg;
  assign ctl_oe = ctl_oe_reg;
  assign cs_oe = cs_oe_reg;
  assign upper_parity_pin_out = 1'b0;
  assign upper_parity_pin_oe = 1'b0;
  assign lower_parity_pin_out = 1'b0;
  assign lower_parity_pin_oe = 1'b0;
  assign wait_pullup_en = pu_reg;
  assign port_c_ie = pcie_reg;
  assign port_c_data = pc_reg;
  assign keep_out = ko_reg;
  assign keep_oe = koe_reg;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic int_act, io_act;
  assign int_act = (st_reg == ST_DATA) && (req_reg.space == SP_INT);
  assign io_act = (st_reg == ST_ADDR || st_reg == ST_DATA) && (req_reg.space == SP_MUXIO);

  property p_int_cs;
    int_act |-> bus_pins.area_selects_n == CS_IDLE;
  endproperty
  a_int_cs: assert property (p_int_cs) else $error("chip select low on internal");

  property p_int_str;
    int_act |-> bus_pins.read_strobe_n && bus_pins.upper_write_strobe_n
      && bus_pins.lower_write_strobe_n;
  endproperty
  a_int_str: assert property (p_int_str) else $error("strobe low on internal");

  property p_int_lanes;
    int_act |-> bus_pins.ad_oe == LANES_NONE
      && bus_pins.address_outputs == req_reg.addr[21:1];
  endproperty
  a_int_lanes: assert property (p_int_lanes) else $error("internal lanes wrong");

  property p_int_ah;
    int_act |-> !bus_pins.address_hold_strobe && bus_pins.upper_column_strobe_n
      && bus_pins.lower_column_strobe_n && bus_pins.row_strobe_n;
  endproperty
  a_int_ah: assert property (p_int_ah) else $error("internal hold strobe wrong");

  property p_io_cs;
    io_act |-> bus_pins.area_selects_n == IO_SEL;
  endproperty
  a_io_cs: assert property (p_io_cs) else $error("I/O select wrong");

  sequence s_addr_ph;
    st_reg == ST_ADDR && bus_pins.address_hold_strobe
      && bus_pins.ad_out == req_reg.addr[15:0];
  endsequence
  sequence s_data_ph;
    st_reg == ST_DATA && !bus_pins.address_hold_strobe;
  endsequence

  property p_mux_order;
    st_reg == ST_IDLE && req_valid && run && req.space == SP_MUXIO
      ##1 pwr_mode == PM_RUN |-> s_addr_ph ##1 s_data_ph;
  endproperty
  a_mux_order: assert property (p_mux_order) else $error("address phase missing");

  property p_ahs_only_addr;
    bus_pins.address_hold_strobe |-> st_reg == ST_ADDR && req_reg.space == SP_MUXIO;
  endproperty
  a_ahs_only_addr: assert property (p_ahs_only_addr) else $error("stray hold strobe");

  property p_io_rd;
    io_act && st_reg == ST_DATA |-> bus_pins.read_strobe_n == req_reg.write;
  endproperty
  a_io_rd: assert property (p_io_rd) else $error("read strobe wrong");

  property p_hbs;
    io_act && req_reg.bus16 |->
      bus_pins.address_bit_zero == (req_reg.size == SZ_LOWER);
  endproperty
  a_hbs: assert property (p_hbs) else $error("byte select wrong");

  property p_no_uws8;
    st_reg == ST_DATA && !req_reg.bus16 |-> bus_pins.upper_write_strobe_n;
  endproperty
  a_no_uws8: assert property (p_no_uws8) else $error("upper strobe in 8-bit");

  property p_lws_read;
    st_reg == ST_DATA && !req_reg.write |-> bus_pins.lower_write_strobe_n;
  endproperty
  a_lws_read: assert property (p_lws_read) else $error("lower strobe on read");

  property p_keep;
    stby ##1 stby |-> $stable(keep_out);
  endproperty
  a_keep: assert property (p_keep) else $error("keep-state output moved");

  property p_float;
    stby && standby_float_bit |=> keep_oe == '0 || !stby;
  endproperty
  a_float: assert property (p_float) else $error("keep pins not floated");

  property p_pullup;
    ##1 wait_pullup_en == $past(wait_pullup_bit);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up mismatch");

  property p_portc;
    pwr_mode == PM_POR |=> !port_c_ie;
  endproperty
  a_portc: assert property (p_portc) else $error("port C enabled in reset");

endmodule : ebp_pin_ctrl

/* test/ebp_mux_peer.sv */
/*
 Model of a peripheral on the multiplexed I/O space.
 Assumes the controller's bus pins and core_clk; returns the shared lines it sees.
*/
`timescale 1ns/10ps
module ebp_mux_peer (
  // Clock
  input wire logic core_clk,
  // Controller pins
  input wire ebp_pkg::ebp_pins_t bus_pins,
  // Resolved shared lines
  output logic [15:0] lines
);
  import ebp_pkg::*;
  logic [15:0] addr_lat = 16'h0;
  logic [15:0] last = 16'h0;
  logic [15:0] peer;
  logic rd_sel;
  assign rd_sel = !bus_pins.area_selects_n[6] && !bus_pins.read_strobe_n;
  // Undriven lanes show the latched address XOR 5a5a on a selected read, else the inverse of their last level
  assign peer = rd_sel ? (addr_lat ^ 16'h5a5a) : ~last;
  assign lines[15:8] = bus_pins.ad_oe[1] ? bus_pins.ad_out[15:8] : peer[15:8];
  assign lines[7:0] = bus_pins.ad_oe[0] ? bus_pins.ad_out[7:0] : peer[7:0];
  always @(posedge core_clk) begin
    last <= lines;
    if (!bus_pins.area_selects_n[6] && bus_pins.address_hold_strobe) begin
      addr_lat <= lines;
    end
  end
endmodule : ebp_mux_peer

/* test/ebp_pin_ctrl_test.sv */
/*
 Self-checking bench for the bus pin controller.
 Assumes the multiplexed peripheral model drives the shared lines.
*/
`timescale 1ns/10ps
module ebp_pin_ctrl_test;
  import ebp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  ebp_req_t req = REQ_RST;
  ebp_pwr_t pwr_mode = PM_RUN;
  logic sep_strobe = 1'b1;
  logic standby_float_bit = 1'b0;
  logic wait_pullup_bit = 1'b0;
  logic wait_n_pin = 1'b1;
  logic [7:0] port_c_inputs = 8'h5a;
  logic [15:0] keep_val = 16'h0;
  logic [15:0] keep_dir = 16'h0;
  logic req_ready, acc_done, ctl_oe, cs_oe, wait_pullup_en, port_c_ie;
  logic upo, upe, lpo, lpe;
  logic [15:0] rd_data, lines, keep_out, keep_oe;
  logic [7:0] port_c_data;
  ebp_pins_t p;
  int fails = 0;
  int comparisons = 0;
  int nacc = 0;

  always #50 core_clk = ~core_clk;

  ebp_pin_ctrl #(.KEEP_W(16)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .acc_done(acc_done),
    .rd_data(rd_data), .pwr_mode(pwr_mode), .sep_strobe(sep_strobe),
    .standby_float_bit(standby_float_bit), .wait_pullup_bit(wait_pullup_bit),
    .bus_pins(p), .ctl_oe(ctl_oe), .cs_oe(cs_oe), .muxed_addr_data_lines_in(lines),
    .upper_parity_pin_out(upo), .upper_parity_pin_oe(upe), .lower_parity_pin_out(lpo),
    .lower_parity_pin_oe(lpe), .wait_n_pin(wait_n_pin), .wait_pullup_en(wait_pullup_en),
    .port_c_inputs(port_c_inputs), .port_c_ie(port_c_ie), .port_c_data(port_c_data),
    .keep_val(keep_val), .keep_dir(keep_dir), .keep_out(keep_out), .keep_oe(keep_oe));

  ebp_mux_peer peer (.core_clk(core_clk), .bus_pins(p), .lines(lines));

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // One access, checked phase by phase
  task automatic acc(input ebp_space_t sp, input logic b16, input ebp_size_t sz,
                     input logic wr, input logic [2:0] ar);
    ebp_req_t r;
    logic [15:0] m;
    logic [1:0] ln;
    int n;
    nacc++;
    r = '{space: sp, area: ar, bus16: b16, size: sz, write: wr,
          addr: 22'h2d5a6 + 22'(nacc), wdata: 16'h9c00 + 16'(nacc * 7)};
    m = !b16 ? 16'h00ff : sz == SZ_UPPER ? 16'hff00 : sz == SZ_LOWER ? 16'h00ff : 16'hffff;
    ln = {m[15], m[0]};
    req = r;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk("ready", 1'b1, req_ready);
    @(negedge core_clk);
    req_valid = 1'b0;
    chk("address", 24'(r.addr[21:1]), 24'(p.address_outputs));
    chk("row col", 3'h7, {p.row_strobe_n, p.upper_column_strobe_n,
        p.lower_column_strobe_n});
    if (sp == SP_MUXIO) begin
      chk("hold addr", 1'b1, p.address_hold_strobe);
      chk("sel addr", IO_SEL, p.area_selects_n);
      chk("oe addr", {b16, 1'b1}, p.ad_oe);
      chk("lanes addr", r.addr[15:0] & {{8{b16}}, 8'hff},
          p.ad_out & {{8{b16}}, 8'hff});
      @(negedge core_clk);
    end
    chk("hold data", 1'b0, p.address_hold_strobe);
    chk("sel data", sp == SP_INT ? CS_IDLE : sp == SP_MUXIO ? IO_SEL : 8'(~(8'h01 << ar)),
        p.area_selects_n);
    chk("ctl cs oe", 2'h3, {ctl_oe, cs_oe});
    if (sp == SP_INT) begin
      chk("strobes", 3'h7, {p.read_strobe_n, p.upper_write_strobe_n,
          p.lower_write_strobe_n});
      chk("oe int", 6'h0, {p.ad_oe, upe, lpe, upo, lpo});
      chk("a0 int", r.addr[0], p.address_bit_zero);
    end else begin
      chk("read", wr, p.read_strobe_n);
      chk("low wr", !(wr && (!sep_strobe || !b16 || sz != SZ_UPPER)),
          p.lower_write_strobe_n);
      if (b16) begin
        chk("up wr", sep_strobe ? !(wr && sz != SZ_LOWER) : sz == SZ_UPPER,
            p.upper_write_strobe_n);
      end else begin
        chk("up wr 8", 1'b1, p.upper_write_strobe_n);
      end
      chk("a0", (b16 && (sp == SP_MUXIO || !sep_strobe)) ? sz == SZ_LOWER : r.addr[0],
          p.address_bit_zero);
      chk("oe data", wr ? ln : 2'h0, p.ad_oe);
      if (wr) begin
        chk("wdata", r.wdata & m, p.ad_out & m);
      end
    end
    @(negedge core_clk);
    chk("done", 1'b1, acc_done);
    chk("sel idle", CS_IDLE, p.area_selects_n);
    if (sp == SP_MUXIO && !wr) begin
      chk("rdata", (r.addr[15:0] ^ 16'h5a5a) & m, rd_data & m);
    end
    @(negedge core_clk);
  endtask : acc

  initial begin
    #(100 * 3000);
    fails++;
    stop_test();
  end

  initial begin
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    acc(SP_INT, 1'b1, SZ_WORD, 1'b0, 3'h0);
    acc(SP_INT, 1'b0, SZ_LOWER, 1'b1, 3'h0);
    for (int s = 0; s < 2; s++) begin
      sep_strobe = s[0];
      for (int b = 0; b < 2; b++) begin
        for (int z = 0; z < 3; z++) begin
          for (int w = 0; w < 2; w++) begin
            acc(SP_MUXIO, b[0], ebp_size_t'(z), w[0], 3'h0);
          end
        end
      end
    end
    for (int a = 0; a < 8; a++) begin
      acc(SP_EXT, 1'b1, SZ_WORD, 1'b1, 3'(a));
    end
    keep_val = 16'ha5c3;
    keep_dir = 16'hffff;
    wait_pullup_bit = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("pullup on", 1'b1, wait_pullup_en);
    pwr_mode = PM_STBY;
    @(negedge core_clk);
    keep_val = 16'h0f0f;
    repeat (3) @(negedge core_clk);
    chk("keep out", 16'ha5c3, keep_out);
    chk("keep oe", 16'hffff, keep_oe);
    chk("ready stby", 1'b0, req_ready);
    standby_float_bit = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("keep float", 16'h0, keep_oe);
    for (int i = 1; i < 6; i++) begin
      pwr_mode = ebp_pwr_t'(i);
      port_c_inputs = 8'h30 + 8'(i);
      repeat (6) @(negedge core_clk);
      chk("port c ie", !(i == 2 || i == 3), port_c_ie);
      chk("ctl cs oe", {!(i == 2 || i == 5), !(i == 2 || i == 3 || i == 5)}, {ctl_oe, cs_oe});
      if (!(i == 2 || i == 3)) begin
        chk("port c data", 8'h30 + 8'(i), port_c_data);
      end
    end
    wait_pullup_bit = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("pullup off", 1'b0, wait_pullup_en);
    stop_test();
  end
endmodule : ebp_pin_ctrl_test
